// *** rtl/epa_cfg.svh ***
// Timing and layout constants for the programmable memory access controller
`ifndef EPA_CFG_SVH
`define EPA_CFG_SVH
// Clock period in ns (20 MHz)
`define EPA_CLK_NS 50
// Address-to-data delay, ns (longest access figure assumed)
`define EPA_ADDR_TO_DATA_NS 150
// Gate-to-data delay, ns
`define EPA_GATE_TO_DATA_NS 70
// Program pulse width, ns (50 us)
`define EPA_PROG_PULSE_NS 50000
// Setup/hold around pulse and verify, ns
`define EPA_SETUP_NS 2000
// Cycle counts, least times rounded up
`define EPA_ACC_CYC ((`EPA_ADDR_TO_DATA_NS + `EPA_CLK_NS - 1) / `EPA_CLK_NS)
`define EPA_GATE_CYC ((`EPA_GATE_TO_DATA_NS + `EPA_CLK_NS - 1) / `EPA_CLK_NS)
`define EPA_PULSE_CYC ((`EPA_PROG_PULSE_NS + `EPA_CLK_NS - 1) / `EPA_CLK_NS)
`define EPA_SETUP_CYC ((`EPA_SETUP_NS + `EPA_CLK_NS - 1) / `EPA_CLK_NS)
// Retry limit for program pulses on one word
`define EPA_MAX_PULSES 25
// Widths
`define EPA_ADDR_W 20
`define EPA_DATA_W 16
`define EPA_CNT_W 12
`endif

// *** rtl/epa_pkg.sv ***
// Types for the programmable memory access controller
`default_nettype none
package epa_pkg;
  // Controller states
  typedef enum logic [3:0] {
    EPA_IDLE, EPA_RSETUP, EPA_RGATE, EPA_RDONE,
    EPA_PSETUP, EPA_PPULSE, EPA_PHOLD, EPA_VGATE, EPA_VCHECK, EPA_PDONE
  } epa_state_t;
  // Request kinds
  typedef enum logic [1:0] {
    EPA_OP_READ, EPA_OP_PROG, EPA_OP_SIG
  } epa_op_t;
endpackage
`default_nettype wire

// *** rtl/epa_wait_timer.sv ***
// Load-and-count-down timer giving a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
`include "epa_cfg.svh"
module epa_wait_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [`EPA_CNT_W-1:0] count,
  output logic done
);
  // Remaining cycles, zero means idle
  logic [`EPA_CNT_W-1:0] remain_q;
  // Count down after load
  always_ff @(posedge mclk) begin
    if (rst) begin
      remain_q <= '0;
    end else if (load) begin
      remain_q <= count;
    end else if (remain_q != '0) begin
      remain_q <= remain_q - `EPA_CNT_W'(1);
    end
  end
  // Pulse when last cycle elapses; independent of load so a reload on done forms no loop
  assign done = (remain_q == `EPA_CNT_W'(1));
endmodule
`default_nettype wire

// *** rtl/epa_host.sv ***
// Host controller driving the programmable memory through its pins
`timescale 1ns/1ps
`default_nettype none
`include "epa_cfg.svh"
module epa_host
  import epa_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [1:0] reqOp,
  input wire logic byteMode,
  input wire logic [`EPA_ADDR_W:0] reqAddr,
  input wire logic [`EPA_DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [`EPA_DATA_W-1:0] rspData,
  output logic rspFail,
  output logic chipSelN,
  output logic outGateN,
  output logic widthSelProgSupply,
  output logic progSupplyHigh,
  output logic signatureEntryLevel,
  output logic [`EPA_ADDR_W-1:0] wordAddress,
  input wire logic [14:0] dataIn,
  output logic [14:0] dataOut,
  output logic dataOeN,
  input wire logic topDataOrLowAddrIn,
  output logic topDataOrLowAddrOut,
  output logic topDataOrLowAddrOeN
);
  // Controller state
  epa_state_t state_q;
  // Latched request
  epa_op_t op_q;
  logic byte_q;
  logic [`EPA_ADDR_W:0] addr_q;
  logic [`EPA_DATA_W-1:0] wdata_q;
  // Program pulse tally
  logic [4:0] pulses_q;
  // Pin synchronisers for returned data
  logic [15:0] dataSync1_q;
  logic [15:0] dataSync2_q;
  // Timer handshake
  logic timerLoad;
  logic [`EPA_CNT_W-1:0] timerCount;
  logic timerDone;

  // Wait timer for access, gate, pulse and setup times
  epa_wait_timer uTimer (
    .mclk(mclk),
    .rst(rst),
    .load(timerLoad),
    .count(timerCount),
    .done(timerDone)
  );

  // Merge masked read word: byte reads land in the low byte
  function automatic logic [15:0] shape_read(input logic [15:0] raw, input logic isByte,
                                             input logic isSig);
    if (isSig) begin
      shape_read = {8'h00, raw[7:0]};
    end else if (isByte) begin
      shape_read = {8'h00, raw[7:0]};
    end else begin
      shape_read = raw;
    end
  endfunction

  // Two flip-flops ahead of any data use
  always_ff @(posedge mclk) begin
    if (rst) begin
      dataSync1_q <= 16'h0000;
      dataSync2_q <= 16'h0000;
    end else begin
      dataSync1_q <= {topDataOrLowAddrIn, dataIn};
      dataSync2_q <= dataSync1_q;
    end
  end

  // Request capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      op_q <= EPA_OP_READ;
      byte_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= 16'h0000;
    end else if (reqValid && reqReady) begin
      op_q <= epa_op_t'(reqOp);
      byte_q <= byteMode && (reqOp == 2'h0);
      addr_q <= reqAddr;
      wdata_q <= reqData;
    end
  end

  // Ready only when idle
  assign reqReady = (state_q == EPA_IDLE);

  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= EPA_IDLE;
      pulses_q <= 5'h00;
      rspValid <= 1'b0;
      rspFail <= 1'b0;
      rspData <= 16'h0000;
    end else begin
      rspValid <= 1'b0;
      case (state_q)
        // Wait for a request
        EPA_IDLE: begin
          pulses_q <= 5'h00;
          if (reqValid) begin
            state_q <= (reqOp == 2'h1) ? EPA_PSETUP : EPA_RSETUP;
          end
        end
        EPA_RSETUP: begin
          if (timerDone) begin
            state_q <= EPA_RGATE;
          end
        end
        EPA_RGATE: begin
          if (timerDone) begin
            state_q <= EPA_RDONE;
          end
        end
        // Capture read data
        EPA_RDONE: begin
          rspData <= shape_read(dataSync2_q, byte_q, op_q == EPA_OP_SIG);
          rspFail <= 1'b0;
          rspValid <= 1'b1;
          state_q <= EPA_IDLE;
        end
        // settle supply and data before pulse
        EPA_PSETUP: begin
          if (timerDone) begin
            state_q <= EPA_PPULSE;
          end
        end
        EPA_PPULSE: begin
          if (timerDone) begin
            pulses_q <= pulses_q + 5'h01;
            state_q <= EPA_PHOLD;
          end
        end
        // Hold data past the pulse end, then release before verify
        EPA_PHOLD: begin
          if (timerDone) begin
            state_q <= EPA_VGATE;
          end
        end
        EPA_VGATE: begin
          if (timerDone) begin
            state_q <= EPA_VCHECK;
          end
        end
        // compare; retry or finish with no extra pulse
        EPA_VCHECK: begin
          if (dataSync2_q == wdata_q) begin
            state_q <= EPA_PDONE;
            rspFail <= 1'b0;
          end else if (pulses_q >= 5'(`EPA_MAX_PULSES)) begin
            state_q <= EPA_PDONE;
            rspFail <= 1'b1;
          end else begin
            state_q <= EPA_PSETUP;
          end
          rspData <= dataSync2_q;
        end
        // Report program result
        EPA_PDONE: begin
          rspValid <= 1'b1;
          state_q <= EPA_IDLE;
        end
        default: begin
          state_q <= EPA_IDLE;
        end
      endcase
    end
  end

  // Timer loads on entering each timed state
  always_comb begin
    timerLoad = 1'b0;
    timerCount = '0;
    case (state_q)
      EPA_IDLE: begin
        timerLoad = reqValid;
        timerCount = (reqOp == 2'h1) ? `EPA_CNT_W'(`EPA_SETUP_CYC)
                                     : `EPA_CNT_W'(`EPA_ACC_CYC);
      end
      EPA_RSETUP: begin
        timerLoad = timerDone;
        timerCount = `EPA_CNT_W'(`EPA_GATE_CYC + 2);
      end
      EPA_PSETUP: begin
        timerLoad = timerDone;
        timerCount = `EPA_CNT_W'(`EPA_PULSE_CYC);
      end
      EPA_PPULSE: begin
        timerLoad = timerDone;
        timerCount = `EPA_CNT_W'(`EPA_SETUP_CYC);
      end
      EPA_PHOLD: begin
        timerLoad = timerDone;
        timerCount = `EPA_CNT_W'(`EPA_ACC_CYC + 2);
      end
      EPA_VCHECK: begin
        timerLoad = (dataSync2_q != wdata_q) && (pulses_q < 5'(`EPA_MAX_PULSES));
        timerCount = `EPA_CNT_W'(`EPA_SETUP_CYC);
      end
      default: begin
        timerLoad = 1'b0;
      end
    endcase
  end

  // Pin drive: select, gate, supply and address
  always_ff @(posedge mclk) begin
    if (rst) begin
      chipSelN <= 1'b1;
      outGateN <= 1'b1;
      widthSelProgSupply <= 1'b1;
      progSupplyHigh <= 1'b0;
      signatureEntryLevel <= 1'b0;
      wordAddress <= '0;
    end else begin
      // select for reads and the program pulse only, not verify; gate as read strobe
      chipSelN <= !(state_q == EPA_RSETUP || state_q == EPA_RGATE || state_q == EPA_PPULSE);
      // gate low only for reads and verify
      outGateN <= !(state_q == EPA_RGATE || state_q == EPA_VGATE || state_q == EPA_VCHECK);
      widthSelProgSupply <= !byte_q;
      // supply high throughout program and verify
      progSupplyHigh <= (state_q >= EPA_PSETUP) && (state_q <= EPA_VCHECK);
      signatureEntryLevel <= (op_q == EPA_OP_SIG) && (state_q == EPA_RSETUP || state_q == EPA_RGATE);
      wordAddress <= addr_q[`EPA_ADDR_W:1];
    end
  end

  // Data and shared top pin drive
  always_ff @(posedge mclk) begin
    if (rst) begin
      dataOut <= 15'h0000;
      dataOeN <= 1'b1;
      topDataOrLowAddrOut <= 1'b0;
      topDataOrLowAddrOeN <= 1'b1;
    end else begin
      // drive data only while gate is high in programming
      dataOeN <= !(state_q == EPA_PSETUP || state_q == EPA_PPULSE || state_q == EPA_PHOLD);
      dataOut <= wdata_q[14:0];
      // byte reads drive extra address on the top pin
      if (byte_q && (state_q == EPA_RSETUP || state_q == EPA_RGATE)) begin
        topDataOrLowAddrOut <= addr_q[0];
        topDataOrLowAddrOeN <= 1'b0;
      end else if (state_q == EPA_PSETUP || state_q == EPA_PPULSE || state_q == EPA_PHOLD) begin
        // Top data bit held through the pulse end like the rest
        topDataOrLowAddrOut <= wdata_q[15];
        topDataOrLowAddrOeN <= 1'b0;
      end else begin
        topDataOrLowAddrOut <= 1'b0;
        topDataOrLowAddrOeN <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/epa_host_asserts.sv ***
// Pin-level checker for the memory access controller
`timescale 1ns/1ps
`default_nettype none
`include "epa_cfg.svh"
module epa_host_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rspValid,
  input wire logic chipSelN,
  input wire logic outGateN,
  input wire logic widthSelProgSupply,
  input wire logic progSupplyHigh,
  input wire logic signatureEntryLevel,
  input wire logic [`EPA_ADDR_W-1:0] wordAddress,
  input wire logic dataOeN,
  input wire logic topDataOrLowAddrOeN
);
  // All checks sample on the controller clock and rest in reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  rst_idle_a: assert property ($fell(rst) |-> chipSelN && outGateN && dataOeN)
    else $error("pins not idle after reset");
  no_contention_a: assert property (!outGateN |-> dataOeN)
    else $error("host drives data while gate low");
  top_wire_a: assert property (!outGateN && widthSelProgSupply |-> topDataOrLowAddrOeN)
    else $error("top pin driven in word read");
  byte_addr_a: assert property (!chipSelN && !widthSelProgSupply && !progSupplyHigh
    |-> !topDataOrLowAddrOeN)
    else $error("byte select not driven");
  prog_pulse_a: assert property (!chipSelN && progSupplyHigh |-> outGateN && !dataOeN)
    else $error("program pulse without gate high and data");
  verify_sel_a: assert property (progSupplyHigh && !outGateN |-> chipSelN)
    else $error("verify with select low");
  sig_entry_a: assert property (signatureEntryLevel && !outGateN
    |-> widthSelProgSupply && !chipSelN && !progSupplyHigh)
    else $error("signature levels wrong");
  addr_hold_a: assert property (!outGateN && !$past(outGateN) |-> $stable(wordAddress))
    else $error("address moved during read");
  gate_wait_a: assert property ($fell(outGateN) |-> !rspValid [*2])
    else $error("answer too soon after gate");
  acc_wait_a: assert property ($fell(chipSelN) && !progSupplyHigh |-> !rspValid [*3])
    else $error("answer too soon after select");
endmodule
`default_nettype wire

// *** tb/epa_mem_model.sv ***
// Behavioural model of the programmable memory at its pins
`timescale 1ns/1ps
`default_nettype none
module epa_mem_model #(
  parameter int ACC_NS = 140, // Output delay, just inside the access time
  parameter int GATE_NS = 60, // Gate-to-output delay, just inside the gate time
  parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C // Arbitrary value
) (
  input wire logic mclk,
  input wire logic chipSelN,
  input wire logic outGateN,
  input wire logic widthSelProgSupply,
  input wire logic progSupplyHigh,
  input wire logic signatureEntryLevel,
  input wire logic [19:0] wordAddress,
  input wire logic [14:0] hostData,
  input wire logic hostDataOeN,
  input wire logic hostTop,
  input wire logic hostTopOeN,
  output wire logic [14:0] dataLine,
  output wire logic topLine
);
  logic [15:0] mem [16]; // Slice of the array, low address bits only
  logic [15:0] word; // Word, byte or code to present
  logic [15:0] lastQ = 16'h0000; // Last line levels
  logic byteRd; // Byte-wide read
  wire drv; // Device drives the lines
  wire drvReq; // Gate and select call for output
  wire drvLate; // Output call after the gate delay
  wire [15:0] devQ; // Delayed output value
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  always @(posedge chipSelN) begin
    if (progSupplyHigh === 1'b1 && outGateN === 1'b1) begin
      mem[wordAddress[3:0]] <= mem[wordAddress[3:0]] & {hostTop, hostData};
    end
  end
  always_comb begin
    byteRd = !widthSelProgSupply && !progSupplyHigh;
    word = mem[wordAddress[3:0]];
    if (signatureEntryLevel) begin
      word = {8'h00, wordAddress[0] ? DEV_CODE : MFR_CODE};
    end else if (byteRd) begin
      word = {8'h00, hostTop ? word[15:8] : word[7:0]};
    end
  end
  // drive only with gate and select, or verify
  assign drvReq = !outGateN && (!chipSelN || progSupplyHigh);
  // Outputs turn on only after the gate delay, off at once
  assign #(GATE_NS) drvLate = drvReq;
  assign drv = drvReq && drvLate;
  assign #(ACC_NS) devQ = word;
  // Released lines show the inverse of their last level
  always @(posedge mclk) lastQ <= {topLine, dataLine};
  assign dataLine[7:0] = !hostDataOeN ? hostData[7:0] : drv ? devQ[7:0] : ~lastQ[7:0];
  assign dataLine[14:8] = !hostDataOeN ? hostData[14:8]
    : (drv && !byteRd) ? devQ[14:8] : ~lastQ[14:8];
  assign topLine = !hostTopOeN ? hostTop : (drv && !byteRd) ? devQ[15] : ~lastQ[15];
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the memory access controller
`timescale 1ns/1ps
`default_nettype none
`include "epa_cfg.svh"
module tb_top;
  import epa_pkg::*;
  localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // Arbitrary value
  logic mclk, rst, reqValid, reqReady, byteMode, rspValid, rspFail, chipSelN, outGateN;
  logic widthSelProgSupply, progSupplyHigh, signatureEntryLevel, dataOeN, topOut, topOeN;
  logic [1:0] reqOp;
  logic [20:0] reqAddr;
  logic [15:0] reqData, rspData;
  logic [19:0] wordAddress;
  logic [14:0] dataOut;
  wire [14:0] dataLine;
  wire topLine;
  int err_total, samples_checked;
  epa_host u_epa_host (.mclk, .rst, .reqValid, .reqReady, .reqOp, .byteMode, .reqAddr,
    .reqData, .rspValid, .rspData, .rspFail, .chipSelN, .outGateN, .widthSelProgSupply,
    .progSupplyHigh, .signatureEntryLevel, .wordAddress, .dataIn(dataLine), .dataOut,
    .dataOeN, .topDataOrLowAddrIn(topLine), .topDataOrLowAddrOut(topOut),
    .topDataOrLowAddrOeN(topOeN));
  epa_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_epa_mem_model (.mclk, .chipSelN,
    .outGateN, .widthSelProgSupply, .progSupplyHigh, .signatureEntryLevel, .wordAddress,
    .hostData(dataOut), .hostDataOeN(dataOeN), .hostTop(topOut), .hostTopOeN(topOeN),
    .dataLine, .topLine);
  // Clock at 50 ns
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Compare one value and count it
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Hold a request until taken, then wait a bounded time for the answer
  task automatic req(input logic [1:0] op, input logic bm, input logic [20:0] a,
    input logic [15:0] d);
    int n;
    reqOp = op;
    byteMode = bm;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    // Ready looked at away from the edge; the next rising edge takes the request
    while (reqReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    check("answer", 16'h1, {15'h0, rspValid});
  endtask
  // Read and compare
  task automatic rd(input logic bm, input logic [20:0] a, input logic [15:0] e, string w);
    req(2'h0, bm, a, 16'h0000);
    check(w, e, rspData);
  endtask
  // Program and compare the outcome flag
  task automatic pg(input logic [19:0] a, input logic [15:0] d, input logic f);
    req(2'h1, 1'b0, {a, 1'b0}, d);
    check("program fail", {15'h0, f}, {15'h0, rspFail});
  endtask
  task automatic test_prog_bytes();
    rd(1'b0, 21'hA, 16'hFFFF, "erased");
    pg(20'h3, 16'hA5C3, 1'b0);
    rd(1'b0, 21'h6, 16'hA5C3, "word");
    rd(1'b1, 21'h6, 16'h00C3, "low byte");
    rd(1'b1, 21'h7, 16'h00A5, "high byte");
    rd(1'b0, 21'h8, 16'hFFFF, "neighbour");
    $display("test_prog_bytes done");
  endtask
  task automatic test_clear_only();
    pg(20'h3, 16'hFFFF, 1'b1);
    rd(1'b0, 21'h6, 16'hA5C3, "zeros kept");
    pg(20'h3, 16'h0500, 1'b0);
    rd(1'b0, 21'h6, 16'h0500, "cleared");
    $display("test_clear_only done");
  endtask
  task automatic test_signature();
    req(2'h2, 1'b0, 21'h0, 16'h0000);
    check("maker code", {8'h00, MFR}, rspData);
    req(2'h2, 1'b0, 21'h2, 16'h0000);
    check("part code", {8'h00, DEV}, rspData);
    $display("test_signature done");
  endtask
  // Print counts and verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    reqValid = 1'b0;
    reqOp = 2'h0;
    byteMode = 1'b0;
    reqAddr = 21'h0;
    reqData = 16'h0000;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    check("select idle", 16'h1, {15'h0, chipSelN});
    test_prog_bytes();
    test_clear_only();
    test_signature();
    results();
  end
  // Watchdog, well beyond the longest retry run
  initial begin
    #(80000 * 50);
    err_total++;
    results();
  end
endmodule
bind epa_host epa_host_asserts u_epa_host_asserts (.mclk, .rst, .rspValid, .chipSelN,
  .outGateN, .widthSelProgSupply, .progSupplyHigh, .signatureEntryLevel, .wordAddress,
  .dataOeN, .topDataOrLowAddrOeN);
`default_nettype wire
